// ---- hdl/mixer_pkg.sv ----
package mixer_pkg;

   // Positions and percentages are in tenths of a percent (0..1000)
   localparam int         POS_W         = 16;
   localparam int         WIDE_W        = 18;
   localparam logic [15:0] POS_MIN      = 16'h0000;
   localparam logic [15:0] POS_MAX      = 16'h03E8;
   localparam logic [15:0] METHANE_LO   = 16'h0190;  // 40 %
   localparam logic [15:0] METHANE_HI   = 16'h0258;  // 60 %

   localparam int CLK_HZ            = 20_000_000;
   localparam int CONTROL_PERIOD_MS = 100;
   localparam int TICK_CYCLES       = CLK_HZ / 1000 * CONTROL_PERIOD_MS;
   // Ramp keeps an extra decimal, so a step is the rate
   localparam int RAMP_SCALE        = 1000 / CONTROL_PERIOD_MS;

   localparam int TABLE_POINTS      = 7;
   localparam int ADDR_W            = 6;
   localparam int CFG_WORDS         = 48;

   localparam logic [5:0] A_CTRL       = 6'h00;
   localparam logic [5:0] A_POWER_THR  = 6'h01;
   localparam logic [5:0] A_STOP_POS   = 6'h02;
   localparam logic [5:0] A_MAN_POS    = 6'h03;
   localparam logic [5:0] A_RAMP_MAN   = 6'h04;
   localparam logic [5:0] A_RAMP_AUTO  = 6'h05;
   localparam logic [5:0] A_CRANK_POS  = 6'h06;  // set 1, set 2 at +1
   localparam logic [5:0] A_CRANK_INC  = 6'h08;
   localparam logic [5:0] A_RUN_POS    = 6'h0A;
   localparam logic [5:0] A_LOW_POS    = 6'h0C;
   localparam logic [5:0] A_START_METH = 6'h0E;
   localparam logic [5:0] A_METH40_POS = 6'h0F;
   localparam logic [5:0] A_METH60_POS = 6'h10;
   localparam logic [5:0] A_HOLD_TICKS = 6'h11;
   localparam logic [5:0] A_DEADBAND   = 6'h12;
   localparam logic [5:0] A_MAX_CORR   = 6'h13;
   localparam logic [5:0] A_FULL_SCALE = 6'h14;
   localparam logic [5:0] A_REG_GAIN   = 6'h15;
   localparam logic [5:0] A_CURVE_LO   = 6'h16;
   localparam logic [5:0] A_CURVE_HI   = 6'h17;
   localparam logic [5:0] A_POWER_TBL  = 6'h18;
   localparam logic [5:0] A_SETP_TBL   = 6'h20;
   localparam logic [5:0] A_BASIC_TBL  = 6'h28;
   localparam logic [5:0] A_REQ_POS    = 6'h30;
   localparam logic [5:0] A_CMD_POS    = 6'h31;
   localparam logic [5:0] A_CORR_VAL   = 6'h32;
   localparam logic [5:0] A_STATUS     = 6'h33;
   localparam logic [5:0] A_MEAS_PCT   = 6'h34;
   localparam logic [5:0] A_ANALOG_OUT = 6'h35;

   localparam int CTRL_AUTO_BIT  = 0;
   localparam int CTRL_OPENCLOSE = 1;
   localparam logic [15:0] RST_CTRL       = 16'h0001;
   localparam logic [15:0] RST_FULL_SCALE = 16'h03E8;
   localparam logic [15:0] RST_CURVE_HI   = 16'h03E8;

   typedef enum logic [5:0] {
      PH_STOPPED  = 6'b000001,
      PH_STOPPING = 6'b000010,
      PH_STARTING = 6'b000100,
      PH_NOLOAD   = 6'b001000,
      PH_LOWPOWER = 6'b010000,
      PH_HIGHLOAD = 6'b100000
   } phase_t;

   typedef struct packed {
      logic       stopped;
      logic       stopping;
      logic       starting;
      logic       running;
      logic       breakerClosed;
      logic [3:0] crankAttempt;
   } engine_t;

   typedef struct packed {
      logic mixerOpenOutput;
      logic mixerCloseOutput;
      logic feedbackMissing;
   } drive_t;

endpackage : mixer_pkg

// ---- hdl/mixer_interp.sv ----
`timescale 1ns/100ps
// Straight-line interpolation, clamped between the two end values
module mixer_interp (
   input  wire logic signed [17:0] x,   // abscissa
   input  wire logic signed [17:0] x0,  // left point
   input  wire logic signed [17:0] x1,  // right point
   input  wire logic signed [17:0] y0,  // value at x0
   input  wire logic signed [17:0] y1,  // value at x1
   output logic signed [17:0]      y    // interpolated value
);
   logic signed [36:0] prod;
   logic signed [36:0] quot;

   always_comb begin
      prod = 37'(x - x0) * 37'(y1 - y0);
      quot = '0;
      if (x1 <= x0 || x <= x0) begin
         y = y0;
      end else if (x >= x1) begin
         y = y1;
      end else begin
         quot = prod / 37'(x1 - x0);
         y    = 18'(37'(y0) + quot);
      end
   end
endmodule : mixer_interp

// ---- hdl/mixer_ramp.sv ----
`timescale 1ns/100ps
// Rate limiter with one extra decimal inside
module mixer_ramp (
   input  wire logic        core_clk, // clock
   input  wire logic        rst,      // async reset
   input  wire logic        tick,     // control period strobe
   input  wire logic        bypass,   // follow target at once
   input  wire logic [15:0] target,   // wanted position
   input  wire logic [15:0] rate,     // 0.1 %/s
   output logic      [15:0] position  // rate-limited position
);
   logic [19:0] value_reg;
   logic [19:0] goal;
   logic [19:0] step;

   assign goal     = 20'(target) * 20'(mixer_pkg::RAMP_SCALE);
   assign step     = 20'(rate);
   assign position = 16'(value_reg / 20'(mixer_pkg::RAMP_SCALE));

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         value_reg <= '0;
      end else if (bypass) begin
         value_reg <= goal;
      end else if (tick) begin
         if (goal > value_reg + step) begin
            value_reg <= value_reg + step;
         end else if (goal + step < value_reg) begin
            value_reg <= value_reg - step;
         end else begin
            value_reg <= goal;
         end
      end
   end
endmodule : mixer_ramp

// ---- hdl/gas_mixer_position_control.sv ----
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module gas_mixer_position_control #(
   parameter int TICK_CYCLES = mixer_pkg::TICK_CYCLES
) (
   input  wire logic              core_clk,         // 20 MHz clock
   input  wire logic              rst,              // async reset
   input  wire logic [5:0]        regAddr,          // register address
   input  wire logic [15:0]       regWrData,        // write data
   input  wire logic              regWr,            // write strobe
   input  wire logic              regRd,            // read strobe
   output logic      [15:0]       regRdData,        // read data, next cycle
   input  wire mixer_pkg::engine_t engine,          // engine sequence state
   input  wire logic [15:0]       activePower,      // power, 0.1 %
   input  wire logic [15:0]       regulatedQuantity,// sensor raw units
   input  wire logic [15:0]       methaneInput,     // methane, 0.1 %
   input  wire logic [15:0]       mixerFeedbackInput, // position, 0.1 %
   input  wire logic              feedbackPresent,  // feedback configured
   input  wire logic signed [15:0] correctionVirtualInput, // 0.1 %
   input  wire logic              correctionPresent, // correction configured
   input  wire logic              mixerModeInput,   // 1 = AUTO
   input  wire logic              mixerModePresent, // mode input configured
   input  wire logic              setSelectInput,   // 1 = set 2
   input  wire logic              setSelectPresent, // select configured
   output logic      [15:0]       mixerAnalogCommand, // curve-mapped command
   output mixer_pkg::drive_t      mixerDrive        // open/close outputs
);
   logic [15:0] cfgReg [mixer_pkg::CFG_WORDS];
   mixer_pkg::phase_t phase_reg;
   mixer_pkg::phase_t phase_next;
   logic [31:0] tickCnt_reg;
   logic        tick;
   logic [15:0] holdCnt_reg;
   logic [15:0] reqPos_reg;
   logic [15:0] corrApplied_reg;
   logic [15:0] measPct_reg;
   logic signed [17:0] regOut_reg;
   logic [15:0] analog_reg;
   mixer_pkg::drive_t drive_reg;

   logic        autoMode, setTwo, openClose, holding, highLoad;
   logic        applyCorr, basicUsed;
   logic [5:0]  setOfs;
   logic [15:0] cmdPos, targetSat;
   logic signed [35:0] regStep;
   logic [17:0] absDiff;
   logic [31:0] measWide;
   logic signed [17:0] autoBase, target, methPos, setpoint, basicPos;
   logic signed [17:0] tblX0, tblX1, spY0, spY1, bsY0, bsY1;
   logic signed [17:0] curveOut, regErr, regSum, regLo, regHi, diff;

   function automatic logic [15:0] sat(input logic signed [17:0] v);
      if (v < 18'sd0) begin
         return mixer_pkg::POS_MIN;
      end else if (v > 18'(mixer_pkg::POS_MAX)) begin
         return mixer_pkg::POS_MAX;
      end
      return v[15:0];
   endfunction : sat

   function automatic logic signed [17:0] cfgS(input logic [5:0] a);
      return 18'(cfgReg[a]);
   endfunction : cfgS

   // Register port
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < mixer_pkg::CFG_WORDS; i++) begin
            cfgReg[i] <= (i == int'(mixer_pkg::A_CTRL)) ? mixer_pkg::RST_CTRL
               : (i == int'(mixer_pkg::A_FULL_SCALE))
                  ? mixer_pkg::RST_FULL_SCALE
               : (i == int'(mixer_pkg::A_CURVE_HI))
                  ? mixer_pkg::RST_CURVE_HI : 16'h0000;
         end
      end else if (regWr && regAddr < 6'(mixer_pkg::CFG_WORDS)) begin
         cfgReg[regAddr] <= regWrData;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         regRdData <= 16'h0000;
      end else if (regRd) begin
         case (regAddr)
            mixer_pkg::A_REQ_POS:    regRdData <= reqPos_reg;
            mixer_pkg::A_CMD_POS:    regRdData <= cmdPos;
            mixer_pkg::A_CORR_VAL:   regRdData <= corrApplied_reg;
            mixer_pkg::A_STATUS:     regRdData <= {5'h00, drive_reg,
                                       autoMode, setTwo, phase_reg};
            mixer_pkg::A_MEAS_PCT:   regRdData <= measPct_reg;
            mixer_pkg::A_ANALOG_OUT: regRdData <= analog_reg;
            default: begin
               if (regAddr < 6'(mixer_pkg::CFG_WORDS)) begin
                  regRdData <= cfgReg[regAddr];
               end else begin
                  regRdData <= 16'h0000;
               end
            end
         endcase
      end else begin
         regRdData <= 16'h0000;
      end
   end

   // Control period
   assign tick = (tickCnt_reg == 32'(TICK_CYCLES - 1));
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tickCnt_reg <= '0;
      end else if (tick) begin
         tickCnt_reg <= '0;
      end else begin
         tickCnt_reg <= tickCnt_reg + 32'd1;
      end
   end

   // Mode and parameter set
   assign autoMode  = mixerModePresent ? mixerModeInput
                      : cfgReg[mixer_pkg::A_CTRL][mixer_pkg::CTRL_AUTO_BIT];
   assign setTwo    = setSelectPresent & setSelectInput;
   assign setOfs    = setTwo ? 6'h01 : 6'h00;
   assign openClose = cfgReg[mixer_pkg::A_CTRL][mixer_pkg::CTRL_OPENCLOSE];
   assign highLoad  = activePower > cfgReg[mixer_pkg::A_POWER_THR];

   // Engine phase
   always_comb begin
      if (engine.stopping) begin
         phase_next = mixer_pkg::PH_STOPPING;
      end else if (engine.stopped) begin
         phase_next = mixer_pkg::PH_STOPPED;
      end else if (engine.starting && !engine.running) begin
         phase_next = mixer_pkg::PH_STARTING;
      end else if (!engine.breakerClosed) begin
         phase_next = mixer_pkg::PH_NOLOAD;
      end else if (highLoad) begin
         phase_next = mixer_pkg::PH_HIGHLOAD;
      end else begin
         phase_next = mixer_pkg::PH_LOWPOWER;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phase_reg <= mixer_pkg::PH_STOPPED;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // Start hold, counted in control periods
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         holdCnt_reg <= 16'h0000;
      end else if (phase_next == mixer_pkg::PH_STARTING
                   && phase_reg != mixer_pkg::PH_STARTING) begin
         holdCnt_reg <= cfgReg[mixer_pkg::A_HOLD_TICKS];
      end else if (phase_reg != mixer_pkg::PH_STARTING) begin
         holdCnt_reg <= 16'h0000;
      end else if (tick && holdCnt_reg != 16'h0000) begin
         holdCnt_reg <= holdCnt_reg - 16'h0001;
      end
   end
   assign holding = autoMode && phase_reg == mixer_pkg::PH_STARTING
                    && holdCnt_reg != 16'h0000;

   // Methane-based cranking position, clamped by the interpolator
   mixer_interp methInterp (
      .x  (18'(methaneInput)),
      .x0 (18'(mixer_pkg::METHANE_LO)),
      .x1 (18'(mixer_pkg::METHANE_HI)),
      .y0 (cfgS(mixer_pkg::A_METH40_POS)),
      .y1 (cfgS(mixer_pkg::A_METH60_POS)),
      .y  (methPos)
   );

   // Automatic base position per phase
   always_comb begin
      applyCorr = 1'b0;
      case (phase_reg)
         mixer_pkg::PH_STOPPED: begin
            autoBase = cfgS(mixer_pkg::A_STOP_POS);
         end
         mixer_pkg::PH_STOPPING: begin
            autoBase = cfgS(mixer_pkg::A_CRANK_POS + setOfs);
         end
         mixer_pkg::PH_STARTING: begin
            applyCorr = 1'b1;
            if (cfgReg[mixer_pkg::A_START_METH] != 16'h0000) begin
               autoBase = methPos;
            end else if (engine.crankAttempt > 4'd1) begin
               autoBase = cfgS(mixer_pkg::A_CRANK_POS + setOfs)
                  + 18'(engine.crankAttempt - 4'd1)
                  * cfgS(mixer_pkg::A_CRANK_INC + setOfs);
            end else begin
               autoBase = cfgS(mixer_pkg::A_CRANK_POS + setOfs);
            end
         end
         mixer_pkg::PH_NOLOAD: begin
            applyCorr = 1'b1;
            autoBase  = cfgS(mixer_pkg::A_RUN_POS + setOfs);
         end
         mixer_pkg::PH_LOWPOWER: begin
            applyCorr = 1'b1;
            autoBase  = cfgS(mixer_pkg::A_LOW_POS + setOfs);
         end
         default: begin
            autoBase = regOut_reg;
         end
      endcase
      applyCorr = applyCorr & correctionPresent & autoMode;
      if (!autoMode) begin
         target = cfgS(mixer_pkg::A_MAN_POS);
      end else if (applyCorr) begin
         target = autoBase + 18'(correctionVirtualInput);
      end else begin
         target = autoBase;
      end
   end
   assign targetSat = sat(target);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reqPos_reg      <= 16'h0000;
         corrApplied_reg <= 16'h0000;
      end else if (!holding) begin
         reqPos_reg      <= targetSat;
         corrApplied_reg <= applyCorr ? correctionVirtualInput : 16'h0000;
      end
   end

   // Power table segment lookup
   always_comb begin
      tblX0 = cfgS(mixer_pkg::A_POWER_TBL);
      tblX1 = cfgS(mixer_pkg::A_POWER_TBL);
      spY0  = cfgS(mixer_pkg::A_SETP_TBL);
      spY1  = cfgS(mixer_pkg::A_SETP_TBL);
      bsY0  = cfgS(mixer_pkg::A_BASIC_TBL);
      bsY1  = cfgS(mixer_pkg::A_BASIC_TBL);
      basicUsed = 1'b0;
      for (int i = 0; i < mixer_pkg::TABLE_POINTS; i++) begin
         if (cfgReg[mixer_pkg::A_BASIC_TBL + 6'(i)] != 16'h0000) begin
            basicUsed = 1'b1;
         end
      end
      for (int i = 0; i < mixer_pkg::TABLE_POINTS - 1; i++) begin
         if (activePower >= cfgReg[mixer_pkg::A_POWER_TBL + 6'(i)]
             && cfgReg[mixer_pkg::A_POWER_TBL + 6'(i + 1)]
                > cfgReg[mixer_pkg::A_POWER_TBL + 6'(i)]) begin
            tblX0 = cfgS(mixer_pkg::A_POWER_TBL + 6'(i));
            tblX1 = cfgS(mixer_pkg::A_POWER_TBL + 6'(i + 1));
            spY0  = cfgS(mixer_pkg::A_SETP_TBL + 6'(i));
            spY1  = cfgS(mixer_pkg::A_SETP_TBL + 6'(i + 1));
            bsY0  = cfgS(mixer_pkg::A_BASIC_TBL + 6'(i));
            bsY1  = cfgS(mixer_pkg::A_BASIC_TBL + 6'(i + 1));
         end
      end
   end

   mixer_interp setpInterp (
      .x  (18'(activePower)),
      .x0 (tblX0),
      .x1 (tblX1),
      .y0 (spY0),
      .y1 (spY1),
      .y  (setpoint)
   );

   mixer_interp basicInterp (
      .x  (18'(activePower)),
      .x0 (tblX0),
      .x1 (tblX1),
      .y0 (bsY0),
      .y1 (bsY1),
      .y  (basicPos)
   );

   // Measurement as 0.1 % of full scale; zero full scale reads as zero
   assign measWide = (cfgReg[mixer_pkg::A_FULL_SCALE] == 16'h0000) ? '0
      : 32'(regulatedQuantity) * 32'(mixer_pkg::POS_MAX)
        / 32'(cfgReg[mixer_pkg::A_FULL_SCALE]);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         measPct_reg <= 16'h0000;
      end else begin
         measPct_reg <= (measWide > 32'(mixer_pkg::POS_MAX))
                        ? mixer_pkg::POS_MAX : measWide[15:0];
      end
   end

   // Integrating regulator; gain is in 1/64 per tick
   assign regErr  = setpoint - 18'(measPct_reg);
   assign regStep = 36'(regErr) * 36'(cfgS(mixer_pkg::A_REG_GAIN));
   assign regSum  = regOut_reg + 18'(regStep >>> 6);
   always_comb begin
      if (basicUsed) begin
         regLo = basicPos - cfgS(mixer_pkg::A_MAX_CORR);
         regHi = basicPos + cfgS(mixer_pkg::A_MAX_CORR);
      end else begin
         regLo = 18'(mixer_pkg::POS_MIN);
         regHi = 18'(mixer_pkg::POS_MAX);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         regOut_reg <= '0;
      end else if (phase_reg != mixer_pkg::PH_HIGHLOAD || !autoMode) begin
         regOut_reg <= 18'(cmdPos); // Bumpless entry
      end else if (tick) begin
         if (regSum < regLo) begin
            regOut_reg <= 18'(sat(regLo));
         end else if (regSum > regHi) begin
            regOut_reg <= 18'(sat(regHi));
         end else begin
            regOut_reg <= 18'(sat(regSum));
         end
      end
   end

   // Ramp; the regulator output bypasses it, so a drop in power
   // ramps from where the regulator left the mixer
   mixer_ramp ramp (
      .core_clk (core_clk),
      .rst      (rst),
      .tick     (tick),
      .bypass   ((autoMode && phase_reg == mixer_pkg::PH_HIGHLOAD)
                 || phase_reg == mixer_pkg::PH_STOPPED),
      .target   ((autoMode && phase_reg == mixer_pkg::PH_HIGHLOAD)
                 ? regOut_reg[15:0] : reqPos_reg),
      .rate     (autoMode ? cfgReg[mixer_pkg::A_RAMP_AUTO]
                 : cfgReg[mixer_pkg::A_RAMP_MAN]),
      .position (cmdPos)
   );

   // Analog command through a two-point conversion curve
   mixer_interp curveInterp (
      .x  (18'(cmdPos)),
      .x0 (18'(mixer_pkg::POS_MIN)),
      .x1 (18'(mixer_pkg::POS_MAX)),
      .y0 (cfgS(mixer_pkg::A_CURVE_LO)),
      .y1 (cfgS(mixer_pkg::A_CURVE_HI)),
      .y  (curveOut)
   );

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         analog_reg <= 16'h0000;
      end else begin
         analog_reg <= sat(curveOut);
      end
   end
   assign mixerAnalogCommand = analog_reg;

   // Open/close drive toward the commanded position
   assign diff    = 18'(cmdPos) - 18'(mixerFeedbackInput);
   assign absDiff = diff[17] ? 18'(-diff) : 18'(diff);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         drive_reg <= '0;
      end else if (!openClose) begin
         drive_reg <= '0;
      end else if (!feedbackPresent) begin
         drive_reg <= '{1'b0, 1'b0, 1'b1};
      end else if (absDiff < 18'(cfgReg[mixer_pkg::A_DEADBAND])) begin
         drive_reg <= '0;
      end else begin
         drive_reg <= '{!diff[17], diff[17], 1'b0};
      end
   end
   assign mixerDrive = drive_reg;

endmodule : gas_mixer_position_control

// ---- verification/mixer_valve_model.sv ----
`timescale 1ns/100ps
// Valve creeps one step per cycle while driven; stops at the end stops
module mixer_valve_model (
   input  wire logic              core_clk, // clock
   input  wire logic              rst,      // async reset
   input  wire mixer_pkg::drive_t drive,    // open/close outputs
   output logic [15:0]            position  // fed-back position
);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         position <= 16'h0000;
      else if (drive.mixerOpenOutput && position < 16'h03E8)
         position <= position + 16'h0001;
      else if (drive.mixerCloseOutput && position != 16'h0000)
         position <= position - 16'h0001;
   end
endmodule : mixer_valve_model

// ---- verification/gas_mixer_position_control_asserts.sv ----
`timescale 1ns/100ps
module gas_mixer_position_control_asserts (
   input wire logic               core_clk,           // clock
   input wire logic               rst,                // reset
   input wire logic [5:0]         regAddr,            // address
   input wire logic               regRd,              // read strobe
   input wire logic [15:0]        regRdData,          // read data
   input wire mixer_pkg::engine_t engine,             // engine state
   input wire logic               feedbackPresent,    // feedback on
   input wire logic               correctionPresent,  // correction on
   input wire logic [15:0]        mixerAnalogCommand, // analog out
   input wire mixer_pkg::drive_t  mixerDrive          // drive outputs
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_drive_exclusive: assert property (
      !(mixerDrive.mixerOpenOutput && mixerDrive.mixerCloseOutput))
      else $error("both drives");
   a_fb_required: assert property (
      !feedbackPresent [*3] |=> !(mixerDrive.mixerOpenOutput
      || mixerDrive.mixerCloseOutput)) else $error("no fb drive");
   a_missing_flag: assert property (
      feedbackPresent [*3] |=> !mixerDrive.feedbackMissing)
      else $error("false missing");
   a_pos_range: assert property (
      regRd && (regAddr == mixer_pkg::A_REQ_POS
      || regAddr == mixer_pkg::A_CMD_POS)
      |=> regRdData <= mixer_pkg::POS_MAX) else $error("pos range");
   a_analog_range: assert property (
      mixerAnalogCommand <= mixer_pkg::POS_MAX) else $error("analog high");
   a_phase_onehot: assert property (
      regRd && regAddr == mixer_pkg::A_STATUS
      |=> $onehot(regRdData[5:0])) else $error("phase code");
   a_corr_stopped: assert property (
      engine.stopped [*4] ##0 (regRd && regAddr == mixer_pkg::A_CORR_VAL)
      |=> regRdData == 16'h0000) else $error("stopped corr");
   a_corr_absent: assert property (
      !correctionPresent [*4] ##0 (regRd
      && regAddr == mixer_pkg::A_CORR_VAL)
      |=> regRdData == 16'h0000) else $error("absent corr");
   a_rd_idle: assert property (
      !$past(regRd) |-> regRdData == 16'h0000) else $error("stale read");
   c_open: cover property (mixerDrive.mixerOpenOutput);
   c_missing: cover property (mixerDrive.feedbackMissing);
   c_status: cover property (regRd && regAddr == mixer_pkg::A_STATUS);
endmodule : gas_mixer_position_control_asserts
bind gas_mixer_position_control gas_mixer_position_control_asserts chk (
   .core_clk, .rst, .regAddr, .regRd, .regRdData, .engine, .feedbackPresent,
   .correctionPresent, .mixerAnalogCommand, .mixerDrive);

// ---- verification/gas_mixer_position_control_tb.sv ----
`timescale 1ns/100ps
module gas_mixer_position_control_tb;
   logic               core_clk = 1'b0;
   logic               rst = 1'b1;
   logic [5:0]         regAddr = 6'h00;
   logic [15:0]        regWrData = 16'h0000;
   logic               regWr = 1'b0;
   logic               regRd = 1'b0;
   logic [15:0]        regRdData, fbPos, analog, rdv, power = 16'h0000;
   logic [15:0]        methane = 16'h0000;
   mixer_pkg::engine_t engine = '0;
   mixer_pkg::drive_t  drive;
   logic               fbOn = 1'b0, corrOn = 1'b0, modeIn = 1'b0;
   logic               modeOn = 1'b0, setIn = 1'b0, setOn = 1'b0;
   int                 failCount = 0, samplesChecked = 0;
   always #25 core_clk = ~core_clk;
   gas_mixer_position_control #(.TICK_CYCLES(10)) uut (.core_clk, .rst,
      .regAddr, .regWrData, .regWr, .regRd, .regRdData, .engine,
      .activePower(power), .regulatedQuantity(16'h0000),
      .methaneInput(methane), .mixerFeedbackInput(fbPos),
      .feedbackPresent(fbOn), .correctionVirtualInput(16'sh0032),
      .correctionPresent(corrOn), .mixerModeInput(modeIn),
      .mixerModePresent(modeOn), .setSelectInput(setIn),
      .setSelectPresent(setOn), .mixerAnalogCommand(analog),
      .mixerDrive(drive));
   mixer_valve_model valve (.core_clk, .rst, .drive, .position(fbPos));
   task automatic endSim();
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : endSim
   task automatic chk(input string n, input logic [15:0] e, g);
      samplesChecked++;
      if (g !== e) begin
         failCount++;
         $display("wrong value %s expected %0d seen %0d", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge core_clk);
      {regAddr, regWrData, regWr} <= {a, d, 1'b1};
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      @(posedge core_clk);
      {regAddr, regRd} <= {a, 1'b1};
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 rdv = regRdData;
   endtask : rd
   task automatic rdChk(input logic [5:0] a, input logic [15:0] e);
      rd(a);
      chk($sformatf("reg %0h", a), e, rdv);
   endtask : rdChk
   task automatic eng(input logic [4:0] b, input logic [3:0] n);
      @(posedge core_clk);
      engine <= mixer_pkg::engine_t'({b, n});
      repeat (4) @(posedge core_clk);
   endtask : eng
   task automatic waitCmd(input logic [15:0] e);
      for (int i = 0; i < 400; i++) begin
         rd(mixer_pkg::A_CMD_POS);
         if (rdv === e)
            return;
      end
      failCount++;
      endSim();
   endtask : waitCmd
   task automatic tStopped();
      wr(mixer_pkg::A_STOP_POS, 16'h012C);
      wr(mixer_pkg::A_MAN_POS, 16'h02BC);
      corrOn <= 1'b1;
      eng(5'h10, 4'h1);
      rdChk(mixer_pkg::A_REQ_POS, 16'h012C);
      rdChk(mixer_pkg::A_CORR_VAL, 16'h0000);
      wr(mixer_pkg::A_CTRL, 16'h0000);
      repeat (4) @(posedge core_clk);
      rdChk(mixer_pkg::A_REQ_POS, 16'h02BC);
      rdChk(mixer_pkg::A_CMD_POS, 16'h02BC);
      {modeOn, modeIn} <= 2'b11;
      repeat (4) @(posedge core_clk);
      rdChk(mixer_pkg::A_REQ_POS, 16'h012C);
      $display("stopped test done");
   endtask : tStopped
   task automatic tStopping();
      wr(mixer_pkg::A_CRANK_POS, 16'h00C8);
      wr(mixer_pkg::A_CRANK_POS + 6'h01, 16'h00FA);
      eng(5'h08, 4'h1);
      rdChk(mixer_pkg::A_REQ_POS, 16'h00C8);
      {setOn, setIn} <= 2'b11;
      repeat (4) @(posedge core_clk);
      rdChk(mixer_pkg::A_REQ_POS, 16'h00FA);
      setOn <= 1'b0;
      repeat (4) @(posedge core_clk);
      rdChk(mixer_pkg::A_REQ_POS, 16'h00C8);
      $display("stopping test done");
   endtask : tStopping
   task automatic tStarting();
      corrOn <= 1'b0;
      wr(mixer_pkg::A_CRANK_INC, 16'h0014);
      wr(mixer_pkg::A_HOLD_TICKS, 16'h0005);
      eng(5'h04, 4'h3);
      rdChk(mixer_pkg::A_REQ_POS, 16'h00C8);
      repeat (60) @(posedge core_clk);
      rdChk(mixer_pkg::A_REQ_POS, 16'h00F0);
      wr(mixer_pkg::A_METH40_POS, 16'h0064);
      wr(mixer_pkg::A_METH60_POS, 16'h01F4);
      wr(mixer_pkg::A_START_METH, 16'h0001);
      methane <= 16'h01F4;
      repeat (4) @(posedge core_clk);
      rdChk(mixer_pkg::A_REQ_POS, 16'h012C);
      methane <= 16'h02BC;
      corrOn <= 1'b1;
      repeat (4) @(posedge core_clk);
      rdChk(mixer_pkg::A_REQ_POS, 16'h0226);
      rdChk(mixer_pkg::A_CORR_VAL, 16'h0032);
      $display("starting test done");
   endtask : tStarting
   task automatic tRunning();
      corrOn <= 1'b0;
      wr(mixer_pkg::A_RUN_POS, 16'h0190);
      wr(mixer_pkg::A_LOW_POS, 16'h01C2);
      wr(mixer_pkg::A_POWER_THR, 16'h01F4);
      wr(mixer_pkg::A_RAMP_AUTO, 16'h0064);
      power <= 16'h0064;
      eng(5'h02, 4'h1);
      rdChk(mixer_pkg::A_REQ_POS, 16'h0190);
      waitCmd(16'h0190);
      eng(5'h03, 4'h1);
      rdChk(mixer_pkg::A_REQ_POS, 16'h01C2);
      rd(mixer_pkg::A_CMD_POS);
      chk("ramp", 16'h0001, 16'(rdv < 16'h01C2));
      waitCmd(16'h01C2);
      power <= 16'h0258;
      repeat (4) @(posedge core_clk);
      rd(mixer_pkg::A_STATUS);
      chk("phase", 16'h0020, rdv & 16'h003F);
      power <= 16'h0064;
      $display("running test done");
   endtask : tRunning
   task automatic tOpenClose();
      wr(mixer_pkg::A_DEADBAND, 16'h0005);
      wr(mixer_pkg::A_CTRL, 16'h0003);
      waitCmd(16'h01C2);
      chk("missing", 16'h0001, 16'(drive.feedbackMissing));
      chk("drive", 16'h0000, 16'({drive.mixerOpenOutput,
         drive.mixerCloseOutput}));
      fbOn <= 1'b1;
      repeat (8) @(posedge core_clk);
      for (int i = 0; i < 1000; i++) begin
         @(posedge core_clk);
         if (drive.mixerOpenOutput === 1'b0
             && drive.mixerCloseOutput === 1'b0)
            break;
      end
      chk("settled", 16'h0001, 16'(fbPos > 16'h01B8
         && fbPos < 16'h01CC));
      $display("open/close test done");
   endtask : tOpenClose
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      tStopped();
      tStopping();
      tStarting();
      tRunning();
      tOpenClose();
      endSim();
   end
endmodule : gas_mixer_position_control_tb
